// ===== hw/ddc_align_pkg.sv
package ddc_align_pkg;

  // ***********************************************************
  // Widths
  // ***********************************************************
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 8;
  localparam int SAMPLE_W  = 16;
  localparam int PHASE_W   = 48;
  localparam int PAIRS     = 2;
  localparam int LANES     = 4;
  localparam int FTW_BYTES = 6;

  // ***********************************************************
  // Register offsets
  // ***********************************************************
  localparam logic [11:0] OFF_PAIR_SELECT = 12'h009;
  localparam logic [11:0] OFF_CHIP_RATIO  = 12'h201;
  localparam logic [11:0] OFF_STATUS      = 12'h202;
  localparam logic [11:0] OFF_CH0_CTRL    = 12'h310;
  localparam logic [11:0] OFF_CH1_CTRL    = 12'h330;
  localparam logic [11:0] OFF_CH0_FTW     = 12'h316;
  localparam logic [11:0] OFF_CH1_FTW     = 12'h336;

  // ***********************************************************
  // Fields and reset values
  // ***********************************************************
  localparam int CTRL_STAGES_LSB = 0;
  localparam int CTRL_C2R_BIT    = 3;
  localparam int CTRL_MODE_LSB   = 4;
  localparam int CTRL_CPLX_BIT   = 7;
  localparam int RATIO_W         = 3;
  localparam logic [2:0] RATIO_MAX_LOG2 = 3'h4;
  localparam logic [7:0] CTRL_RESET     = 8'h00;
  localparam logic [2:0] RATIO_RESET    = 3'h0;
  localparam logic [7:0] PAIR_RESET     = 8'h00;
  localparam logic [7:0] UNMAPPED_READ  = 8'h00;

  // Forced test level, 0.9599 of positive full scale
  localparam logic [15:0] TEST_LEVEL = 16'h7ADD;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [1:0] {
    MODE_VARIABLE    = 2'h0,
    MODE_ZERO_OFFSET = 2'h1,
    MODE_QUARTER     = 2'h2,
    MODE_TEST        = 2'h3
  } if_mode_type;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } sample_type;

  typedef struct packed {
    logic        i_valid;
    logic        q_valid;
    logic [15:0] i;
    logic [15:0] q;
  } chan_out_type;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_type;

  // Mask of the low log2 bits of the common sample counter
  function automatic logic [3:0] low_mask(input logic [2:0] log2);
    logic [4:0] m;
    m = ~(5'h1F << log2);
    return m[3:0];
  endfunction : low_mask

endpackage : ddc_align_pkg

// ===== hw/ddc_lane.sv
`timescale 1ns/1ns

module ddc_lane
(
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  input  wire logic                        i_sample_valid,
  input  ddc_align_pkg::sample_type        i_sample,
  input  wire logic [3:0]                  i_phase_count,
  input  wire logic [7:0]                  i_ctrl,
  input  wire logic [47:0]                 i_ftw,
  input  wire logic [2:0]                  i_ratio_log2,
  output ddc_align_pkg::chan_out_type      o_out
);

  // ***********************************************************
  // Control decode
  // ***********************************************************
  ddc_align_pkg::if_mode_type mode;
  wire logic [1:0] stages;
  wire logic       to_real;
  wire logic       cplx_in;
  wire logic [2:0] dec_log2;
  wire logic       cfg_ok;
  wire logic       update;
  wire logic       slot;

  assign mode    = ddc_align_pkg::if_mode_type'(
                     i_ctrl[ddc_align_pkg::CTRL_MODE_LSB +: 2]);
  assign stages  = i_ctrl[ddc_align_pkg::CTRL_STAGES_LSB +: 2];
  assign to_real = i_ctrl[ddc_align_pkg::CTRL_C2R_BIT];
  assign cplx_in = i_ctrl[ddc_align_pkg::CTRL_CPLX_BIT];
  // Real output halves the factor of the same chain
  assign dec_log2 = {1'b0, stages} + {2'b00, ~to_real};
  // Channel slower than or equal to the slot rate only; covers
  // the missing real output at ratio sixteen as well
  assign cfg_ok = (i_ratio_log2 <= ddc_align_pkg::RATIO_MAX_LOG2)
                  && (dec_log2 >= i_ratio_log2);
  assign update = i_sample_valid && cfg_ok
                  && ((i_phase_count
                       & ddc_align_pkg::low_mask(dec_log2)) == 4'h0);
  assign slot   = i_sample_valid
                  && ((i_phase_count
                       & ddc_align_pkg::low_mask(i_ratio_log2)) == 4'h0);

  // ***********************************************************
  // Oscillator
  // ***********************************************************
  logic [47:0] nco_q;
  logic [1:0]  quarter_q;

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      nco_q     <= 48'h0;
      quarter_q <= 2'h0;
    end
    else if (i_sample_valid)
    begin
      case (mode)
        ddc_align_pkg::MODE_VARIABLE: nco_q <= nco_q + i_ftw;
        ddc_align_pkg::MODE_TEST:     nco_q <= nco_q + i_ftw;
        ddc_align_pkg::MODE_QUARTER:  quarter_q <= quarter_q + 2'h1;
        default:                      nco_q <= 48'h0;
      endcase
    end
  end

  // ***********************************************************
  // Mixer
  // ***********************************************************
  // The oscillator is coarse: only its top two phase bits pick a
  // quarter-turn rotation, which keeps the mixer multiplier-free
  wire logic [1:0]  rot;
  wire logic [15:0] src_i;
  wire logic [15:0] src_q;
  logic      [15:0] mix_i;
  logic      [15:0] mix_q;

  assign rot   = (mode == ddc_align_pkg::MODE_QUARTER) ? quarter_q :
                 (mode == ddc_align_pkg::MODE_ZERO_OFFSET) ? 2'h0 :
                 nco_q[47:46];
  assign src_i = (mode == ddc_align_pkg::MODE_TEST)
                 ? ddc_align_pkg::TEST_LEVEL : i_sample.i;
  assign src_q = ((mode == ddc_align_pkg::MODE_TEST) || !cplx_in)
                 ? 16'h0000 : i_sample.q;

  // Negating full-scale negative wraps; accepted for this path
  always_comb
  begin
    case (rot)
      2'h1:
      begin
        mix_i = src_q;
        mix_q = -src_i;
      end
      2'h2:
      begin
        mix_i = -src_i;
        mix_q = -src_q;
      end
      2'h3:
      begin
        mix_i = -src_q;
        mix_q = src_i;
      end
      default:
      begin
        mix_i = src_i;
        mix_q = src_q;
      end
    endcase
  end

  // ***********************************************************
  // Output hold and repeat
  // ***********************************************************
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_out <= '0;
    end
    else
    begin
      if (update)
      begin
        o_out.i <= mix_i;
        o_out.q <= to_real ? 16'h0000 : mix_q;
      end
      // Between updates the held value is sent again
      o_out.i_valid <= slot && cfg_ok;
      o_out.q_valid <= slot && cfg_ok && !to_real;
    end
  end

endmodule : ddc_lane

// ===== hw/ddc_rate_alignment_and_translation.sv
// Behaviour
// - Real output decimates by 1,2,4,8; complex by 2,4,8,16 for 1-4 stages.
// - Channels slower than chip ratio repeat each value over several slots.
// - Chip ratio one: one slot per input sample.
// - Chip ratio two: real 2,4,8 and complex 2,4,8,16 supported.
// - Chip ratio four: real 4,8 and complex 4,8,16; slower ones repeat.
// - Chip ratio eight: real 8 only, complex 8 or 16.
// - Chip ratio sixteen: no real output, complex factor 16 only.
// - Real output drives only the in-phase port; complex drives both.
// - A pair aligns to a common input sample; updates at multiples of D.
// - Translation uses a 48-bit phase oscillator with a quadrature mixer.
// - Two-bit mode field at bits 5:4 of each channel control register.
// - Channel control writes go to the pair chosen by the pair index.
// - Variable mode runs oscillator and mixer from the tuning word.
// - Zero-offset mode bypasses the mixer and stops the oscillator.
// - Quarter-rate mode applies a fixed quarter-sample-rate shift.
// - Test mode forces input to 0.9599 full scale, oscillator running.
`timescale 1ns/1ns

module ddc_rate_alignment_and_translation
(
  input  wire logic                        i_clk,
  input  wire logic                        i_resetn,
  input  ddc_align_pkg::reg_req_type       i_reg,
  output logic [7:0]                       o_reg_rdata,
  output logic                             o_reg_ack,
  input  wire logic                        i_sample_valid,
  input  ddc_align_pkg::sample_type [1:0]  i_sample,
  output logic [1:0]                       o_slot_valid,
  output ddc_align_pkg::chan_out_type [3:0] o_chan
);

  // ***********************************************************
  // Reset release
  // ***********************************************************
  logic rst_meta_q;
  logic rst_n_q;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ***********************************************************
  // Address decode
  // ***********************************************************
  logic [7:0]  pair_q;
  logic [2:0]  ratio_q [0:1];
  logic [7:0]  ctrl_q  [0:3];
  logic [47:0] ftw_q   [0:3];

  wire logic       hit_pair;
  wire logic       hit_ratio;
  wire logic       hit_status;
  wire logic       hit_ctrl0;
  wire logic       hit_ctrl1;
  wire logic       hit_ftw0;
  wire logic       hit_ftw1;
  wire logic [2:0] ftw_byte;
  wire logic       sel_pair;
  wire logic       sel_ch;
  wire logic [1:0] sel_lane;
  wire logic [11:0] ftw_base;
  wire logic [11:0] ftw_off;

  assign hit_pair   = i_reg.addr == ddc_align_pkg::OFF_PAIR_SELECT;
  assign hit_ratio  = i_reg.addr == ddc_align_pkg::OFF_CHIP_RATIO;
  assign hit_status = i_reg.addr == ddc_align_pkg::OFF_STATUS;
  assign hit_ctrl0  = i_reg.addr == ddc_align_pkg::OFF_CH0_CTRL;
  assign hit_ctrl1  = i_reg.addr == ddc_align_pkg::OFF_CH1_CTRL;
  assign hit_ftw0   = (i_reg.addr >= ddc_align_pkg::OFF_CH0_FTW)
                      && (i_reg.addr < ddc_align_pkg::OFF_CH0_FTW
                          + 12'(ddc_align_pkg::FTW_BYTES));
  assign hit_ftw1   = (i_reg.addr >= ddc_align_pkg::OFF_CH1_FTW)
                      && (i_reg.addr < ddc_align_pkg::OFF_CH1_FTW
                          + 12'(ddc_align_pkg::FTW_BYTES));
  assign ftw_base   = hit_ftw1 ? ddc_align_pkg::OFF_CH1_FTW
                               : ddc_align_pkg::OFF_CH0_FTW;
  assign ftw_off    = i_reg.addr - ftw_base;
  assign ftw_byte   = ftw_off[2:0];
  assign sel_pair   = pair_q[0];
  assign sel_ch     = hit_ctrl1 || hit_ftw1;
  assign sel_lane   = {sel_pair, sel_ch};

  // ***********************************************************
  // Global registers
  // ***********************************************************
  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pair_q     <= ddc_align_pkg::PAIR_RESET;
      ratio_q[0] <= ddc_align_pkg::RATIO_RESET;
      ratio_q[1] <= ddc_align_pkg::RATIO_RESET;
    end
    else if (i_reg.wr)
    begin
      if (hit_pair)
        pair_q <= i_reg.wdata;
      if (hit_ratio)
        ratio_q[sel_pair] <= i_reg.wdata[2:0];
    end
  end

  // ***********************************************************
  // Per lane control storage and datapath
  // ***********************************************************
  wire ddc_align_pkg::chan_out_type lane_out [0:3];
  logic [3:0] cnt_q [0:1];

  genvar g;
  generate
    for (g = 0; g < ddc_align_pkg::LANES; g = g + 1)
    begin : g_lane
      wire logic wr_ctrl;
      wire logic wr_ftw;

      // Only the lane in the chosen pair takes the write
      assign wr_ctrl = i_reg.wr && (hit_ctrl0 || hit_ctrl1)
                       && (sel_lane == 2'(g));
      assign wr_ftw  = i_reg.wr && (hit_ftw0 || hit_ftw1)
                       && (sel_lane == 2'(g));

      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          ctrl_q[g] <= ddc_align_pkg::CTRL_RESET;
          ftw_q[g]  <= 48'h0;
        end
        else
        begin
          if (wr_ctrl)
            ctrl_q[g] <= i_reg.wdata;
          if (wr_ftw)
            ftw_q[g][{ftw_byte, 3'h0} +: 8] <= i_reg.wdata;
        end
      end

      ddc_lane ddc_lane_inst
      (
        .i_clk          (i_clk),
        .i_rst_n        (rst_n_q),
        .i_sample_valid (i_sample_valid),
        .i_sample       (i_sample[g / 2]),
        .i_phase_count  (cnt_q[g / 2]),
        .i_ctrl         (ctrl_q[g]),
        .i_ftw          (ftw_q[g]),
        .i_ratio_log2   (ratio_q[g / 2]),
        .o_out          (lane_out[g])
      );
    end
  endgenerate

  // One driver for the whole port; lane outputs are already registered
  assign o_chan = {lane_out[3], lane_out[2], lane_out[1], lane_out[0]};

  // ***********************************************************
  // Common sample counter and slot strobe per pair
  // ***********************************************************
  genvar p;
  generate
    for (p = 0; p < ddc_align_pkg::PAIRS; p = p + 1)
    begin : g_pair
      wire logic slot_now;

      assign slot_now = i_sample_valid
                        && ((cnt_q[p] & ddc_align_pkg::low_mask(ratio_q[p]))
                            == 4'h0);

      always_ff @(posedge i_clk or negedge rst_n_q)
      begin
        if (!rst_n_q)
        begin
          cnt_q[p]        <= 4'h0;
          o_slot_valid[p] <= 1'b0;
        end
        else
        begin
          // Both lanes of the pair share this count, so they
          // sample the same input for alignment
          if (i_sample_valid)
            cnt_q[p] <= cnt_q[p] + 4'h1;
          o_slot_valid[p] <= slot_now;
        end
      end
    end
  endgenerate

  // ***********************************************************
  // Read path
  // ***********************************************************
  wire logic [7:0] status_val;
  wire logic [7:0] ftw_read;
  wire logic [7:0] rd_val;

  // Bit 1 shows the in-phase valid of channel 1 of the chosen pair, or its control at 8'hFF; bit 0 reads zero
  assign status_val = {6'h00,
                       lane_out[{sel_pair, 1'b1}].i_valid
                       || (ctrl_q[{sel_pair, 1'b1}] == 8'hFF),
                       1'b0};
  assign ftw_read   = ftw_q[sel_lane][{ftw_byte, 3'h0} +: 8];
  assign rd_val     = hit_pair   ? pair_q :
                      hit_ratio  ? {5'h00, ratio_q[sel_pair]} :
                      hit_status ? status_val :
                      (hit_ctrl0 || hit_ctrl1) ? ctrl_q[sel_lane] :
                      (hit_ftw0 || hit_ftw1) ? ftw_read :
                      ddc_align_pkg::UNMAPPED_READ;

  always_ff @(posedge i_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_reg_rdata <= 8'h00;
      o_reg_ack   <= 1'b0;
    end
    else
    begin
      o_reg_ack <= i_reg.rd || i_reg.wr;
      if (i_reg.rd)
        o_reg_rdata <= rd_val;
    end
  end

endmodule : ddc_rate_alignment_and_translation

// ===== sim/ddc_align_checker.sv
`timescale 1ns/1ns

module ddc_align_checker
(
  input  wire logic                         i_clk,
  input  wire logic                         i_resetn,
  input  ddc_align_pkg::reg_req_type        i_reg,
  input  logic [7:0]                        o_reg_rdata,
  input  logic                              o_reg_ack,
  input  wire logic                         i_sample_valid,
  input  ddc_align_pkg::sample_type [1:0]   i_sample,
  input  logic [1:0]                        o_slot_valid,
  input  ddc_align_pkg::chan_out_type [3:0] o_chan
);
  // *******
  // Shadow of pair 0 set-up
  // *******
  // Only pair 0 channel 0 is shadowed, to keep the helper logic small
  logic [7:0] ctrl_q;
  logic [2:0] ratio_q;
  logic       sel_q;
  logic [3:0] cnt_q;
  logic [2:0] dl;
  logic       ok;
  logic       r_al;
  logic       d_al;
  assign dl   = {1'b0, ctrl_q[1:0]} + {2'h0, ~ctrl_q[3]};
  assign ok   = (dl >= ratio_q) && (ratio_q <= 3'h4);
  assign r_al = (cnt_q & ~(4'hF << ratio_q)) == 4'h0;
  assign d_al = (cnt_q & ~(4'hF << dl)) == 4'h0;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      {ctrl_q, ratio_q, sel_q, cnt_q} <= '0;
    end
    else
    begin
      if (i_reg.wr && i_reg.addr == ddc_align_pkg::OFF_PAIR_SELECT)
        sel_q <= i_reg.wdata[0];
      if (i_reg.wr && !sel_q && i_reg.addr == ddc_align_pkg::OFF_CH0_CTRL)
        ctrl_q <= i_reg.wdata;
      if (i_reg.wr && !sel_q && i_reg.addr == ddc_align_pkg::OFF_CHIP_RATIO)
        ratio_q <= i_reg.wdata[2:0];
      if (i_sample_valid)
        cnt_q <= cnt_q + 4'h1;
    end
  end

  // *******
  // Properties
  // *******
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence req_s;
    i_reg.wr || i_reg.rd;
  endsequence
  sequence upd_s;
    i_sample_valid && ok && d_al;
  endsequence

  AST_ACK_AFTER_REQ: assert property (req_s |=> o_reg_ack)
    else $error("register request not acknowledged");
  AST_ACK_CAUSE: assert property (
      o_reg_ack |-> $past(i_reg.wr || i_reg.rd))
    else $error("acknowledge without request");
  AST_CTRL_READBACK: assert property (
      i_reg.rd && !sel_q && i_reg.addr == ddc_align_pkg::OFF_CH0_CTRL
      |=> o_reg_rdata == $past(ctrl_q))
    else $error("control readback wrong");
  AST_SLOT_ALIGN: assert property (
      i_sample_valid && ratio_q <= 3'h4
      |=> o_slot_valid[0] == $past(r_al))
    else $error("slot not on aligned sample");
  AST_SLOT_CAUSE: assert property (
      o_slot_valid[0] |-> $past(i_sample_valid))
    else $error("slot without sample");
  AST_CHAN_UPDATE: assert property (
      upd_s ##0 ctrl_q[5:4] == 2'h1
      |=> o_chan[0].i_valid && o_chan[0].i == $past(i_sample[0].i))
    else $error("channel value not from aligned sample");
  // Output reflects the set-up of the cycle before
  AST_REAL_Q_QUIET: assert property (
      o_chan[0].i_valid && $past(ctrl_q[3])
      |-> !o_chan[0].q_valid && o_chan[0].q == 16'h0)
    else $error("real output drives quadrature");
  AST_VALID_IN_SLOT: assert property (
      (o_chan[0].i_valid || o_chan[1].i_valid) |-> o_slot_valid[0])
    else $error("channel valid outside slot");
  AST_REFUSED_SILENT: assert property (
      i_sample_valid && !ok |=> !o_chan[0].i_valid)
    else $error("unsupported factor gave output");
  AST_HOLD: assert property (
      !o_chan[0].i_valid |-> $stable(o_chan[0].i))
    else $error("channel value changed between slots");
endmodule : ddc_align_checker

bind ddc_rate_alignment_and_translation
  ddc_align_checker ddc_align_checker_inst
(
  .i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_reg(i_reg),
  .o_reg_rdata(o_reg_rdata),
  .o_reg_ack(o_reg_ack),
  .i_sample_valid(i_sample_valid),
  .i_sample(i_sample),
  .o_slot_valid(o_slot_valid),
  .o_chan(o_chan)
);

// ===== sim/ddc_link_receiver.sv
`timescale 1ns/1ns

module ddc_link_receiver
(
  input  wire logic                         i_clk,
  input  logic [1:0]                        i_slot_valid,
  input  ddc_align_pkg::chan_out_type [3:0] i_chan
);
  // *******
  // Slot capture
  // *******
  // No back-pressure on the link, so every slot is taken as it comes
  logic [67:0] slots[$];
  logic [67:0] slots1[$];

  always @(posedge i_clk)
  begin
    if (i_slot_valid[0])
      slots.push_back({i_chan[1], i_chan[0]});
    if (i_slot_valid[1])
      slots1.push_back({i_chan[3], i_chan[2]});
  end
endmodule : ddc_link_receiver

// ===== sim/tb_ddc_rate_alignment_and_translation.sv
`timescale 1ns/1ns

module tb_ddc_rate_alignment_and_translation;
  typedef struct packed {
    logic [2:0] ratio;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
  } row_type;

  logic                              clk;
  logic                              resetn;
  ddc_align_pkg::reg_req_type        req;
  logic [7:0]                        rdata;
  logic                              ack;
  logic                              svalid;
  ddc_align_pkg::sample_type [1:0]   samp;
  logic [1:0]                        slot;
  ddc_align_pkg::chan_out_type [3:0] chan;
  int                                failures;
  int                                compares;
  logic [7:0]                        rd;
  logic [67:0]                       got[$];
  logic [67:0]                       got1[$];
  logic [11:0]                       addrs[6] = '{12'h009, 12'h310, 12'h330,
                                                  12'h201, 12'h202, 12'h0FF};
  row_type rows[7] = '{
    '{3'h0, 8'h98, 8'h93},
    '{3'h1, 8'h99, 8'h90},
    '{3'h2, 8'h91, 8'h9B},
    '{3'h3, 8'h9B, 8'h93},
    '{3'h3, 8'h9A, 8'h92},
    '{3'h4, 8'h9B, 8'h93},
    '{3'h0, 8'hB0, 8'h81}};

  ddc_rate_alignment_and_translation ddc_rate_alignment_and_translation_inst
  (
    .i_clk(clk), .i_resetn(resetn), .i_reg(req), .o_reg_rdata(rdata),
    .o_reg_ack(ack), .i_sample_valid(svalid), .i_sample(samp),
    .o_slot_valid(slot), .o_chan(chan)
  );
  ddc_link_receiver ddc_link_receiver_inst
  (
    .i_clk(clk), .i_slot_valid(slot), .i_chan(chan)
  );

  always #10 clk = ~clk;

  // *******
  // Tasks
  // *******
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (failures == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : wrap_up

  // Strobes are one-cycle pulses; the answer is awaited under a bound
  task automatic reg_op(input logic w, input logic [11:0] a,
                        input logic [7:0] d);
    int n;
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    // Ack stands only in the cycle after the taking edge; read data holds until the next read
    @(negedge clk);
    for (n = 0; n < 3 && ack !== 1'b1; n++)
      @(negedge clk);
    check(36'(ack), 36'h1);
    if (ack !== 1'b1)
      wrap_up();
    else
      rd = rdata;
  endtask : reg_op

  task automatic do_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic stream;
    int k;
    ddc_link_receiver_inst.slots.delete();
    ddc_link_receiver_inst.slots1.delete();
    for (k = 0; k < 32; k++)
    begin
      @(posedge clk);
      svalid <= 1'b1;
      samp[0] <= '{16'h0100 + k[15:0], 16'h0200 + k[15:0]};
      samp[1] <= '{~k[15:0], k[15:0]};
    end
    @(posedge clk);
    svalid <= 1'b0;
    repeat (2) @(posedge clk);
    got = ddc_link_receiver_inst.slots;
    got1 = ddc_link_receiver_inst.slots1;
  endtask : stream

  // Value of one channel in the slot at sample k, zero-offset input ramp
  function automatic logic [33:0] expect_chan(input logic [7:0] c,
                                              input logic [2:0] r,
                                              input int k);
    logic [2:0]  dl;
    logic [15:0] v;
    dl = {1'b0, c[1:0]} + {2'h0, ~c[3]};
    if (dl < r || r > 3'h4)
      return 34'h0;
    v = 16'((k >> dl) << dl);
    return {1'b1, ~c[3], (c[5:4] == 2'h3) ? 16'h7ADD : 16'h0100 + v,
            (c[3] || c[5:4] == 2'h3) ? 16'h0000 : 16'h0200 + v};
  endfunction : expect_chan

  // *******
  // Sequence
  // *******
  initial
  begin
    row_type     e;
    logic [33:0] x;
    clk = 1'b0;
    resetn = 1'b0;
    req = '0;
    svalid = 1'b0;
    samp = '0;
    failures = 0;
    compares = 0;
    foreach (rows[j])
    begin
      e = rows[j];
      do_reset();
      reg_op(1'b1, ddc_align_pkg::OFF_PAIR_SELECT, 8'h00);
      reg_op(1'b1, ddc_align_pkg::OFF_CHIP_RATIO, {5'h00, e.ratio});
      reg_op(1'b1, ddc_align_pkg::OFF_CH0_CTRL, e.ctrl0);
      reg_op(1'b1, ddc_align_pkg::OFF_CH1_CTRL, e.ctrl1);
      stream();
      check(36'(got.size()), 36'(32 >> e.ratio));
      foreach (got[s])
      begin
        x = expect_chan(e.ctrl0, e.ratio, s << e.ratio);
        check(36'(got[s][33:0]), 36'(x));
        x = expect_chan(e.ctrl1, e.ratio, s << e.ratio);
        check(36'(got[s][67:34]), 36'(x));
      end
    end
    do_reset();
    foreach (addrs[a])
    begin
      reg_op(1'b0, addrs[a], 8'h00);
      check(36'(rd), 36'h0);
    end
    reg_op(1'b1, ddc_align_pkg::OFF_PAIR_SELECT, 8'h01);
    reg_op(1'b1, ddc_align_pkg::OFF_CH1_CTRL, 8'hA5);
    reg_op(1'b1, 12'h0FF, 8'h5A);
    reg_op(1'b0, ddc_align_pkg::OFF_CH1_CTRL, 8'h00);
    check(36'(rd), 36'hA5);
    reg_op(1'b0, 12'h0FF, 8'h00);
    check(36'(rd), 36'h0);
    reg_op(1'b1, ddc_align_pkg::OFF_PAIR_SELECT, 8'h00);
    reg_op(1'b0, ddc_align_pkg::OFF_CH1_CTRL, 8'h00);
    check(36'(rd), 36'h0);
    do_reset();
    reg_op(1'b1, ddc_align_pkg::OFF_CH0_CTRL, 8'hA0);
    reg_op(1'b1, ddc_align_pkg::OFF_CH1_CTRL, 8'h80);
    reg_op(1'b1, ddc_align_pkg::OFF_CH1_FTW + 12'h005, 8'h40);
    reg_op(1'b0, ddc_align_pkg::OFF_CH1_FTW + 12'h005, 8'h00);
    check(36'(rd), 36'h40);
    reg_op(1'b1, ddc_align_pkg::OFF_PAIR_SELECT, 8'h01);
    reg_op(1'b1, ddc_align_pkg::OFF_CH0_CTRL, 8'h90);
    stream();
    check(36'(got.size()), 36'h20);
    check(36'(got1.size()), 36'h20);
    foreach (got[s])
    begin
      // Half turn on every second update of a factor-2 channel
      x = expect_chan(8'h90, 3'h0, s);
      if (s[1])
        x = {2'h3, -x[31:16], -x[15:0]};
      check(36'(got[s][33:0]), 36'(x));
      check(36'(got[s][67:34]), 36'(x));
    end
    foreach (got1[s])
    begin
      x = {2'h3, ~16'((s >> 1) << 1), 16'((s >> 1) << 1)};
      check(36'(got1[s][33:0]), 36'(x));
      x[15:0] = 16'h0000;
      check(36'(got1[s][67:34]), 36'(x));
    end
    wrap_up();
  end
endmodule : tb_ddc_rate_alignment_and_translation
